// ---- tcw_pkg.sv ----
// Package for the transfer count and width configuration block.
// Assumes a 32-bit APB register bus with word-aligned registers.
`default_nettype none
package tcw_pkg;
	localparam logic [7:0] TCW_OFF_COUNT_LOW   = 8'h00;
	localparam logic [7:0] TCW_OFF_COUNT_UPPER = 8'h04;
	localparam logic [7:0] TCW_OFF_WIDTH       = 8'h08;
	localparam logic [7:0] TCW_OFF_CONTROL     = 8'h0C;
	localparam logic [7:0] TCW_OFF_STATUS      = 8'h10;
	localparam int         TCW_FIELD_W         = 3;
	localparam int         TCW_LOW_W           = 8;
	localparam int         TCW_COUNT_W         = 14;
	localparam logic [2:0] TCW_FIELD_RST       = 3'h0;
	localparam logic [7:0] TCW_LOW_RST         = 8'h00;
	localparam logic       TCW_SELECT_RST      = 1'b0;
	localparam int         TCW_CTRL_SEL_BIT    = 0;
	localparam int         TCW_STAT_BUSY_BIT   = 0;
	localparam logic [3:0] TCW_FULL_ELEMENT    = 4'h8;
	typedef logic [13:0] tcw_count_t;
endpackage : tcw_pkg
`default_nettype wire

// ---- tcw_cfg_if.sv ----
// Interface carrying configuration fields from the register file to the decoder.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface tcw_cfg_if;
	logic       byte_count_select;
	logic [2:0] count_upper_field;
	logic [7:0] count_low;
	logic [2:0] width_field;
	tcw_pkg::tcw_count_t transfer_count;
	logic [3:0] element_bits;
	modport regs (output byte_count_select, count_upper_field, count_low, width_field,
		input transfer_count, element_bits);
	modport dec (input byte_count_select, count_upper_field, count_low, width_field,
		output transfer_count, element_bits);
endinterface : tcw_cfg_if
`default_nettype wire

// ---- tcw_decode.sv ----
// Assembles the transfer counter and element size from the register fields.
// Assumes the fields are stable while the engine is busy.
`timescale 1ns/1ps
`default_nettype none
module tcw_decode (
	tcw_cfg_if.dec cfg
);
	import tcw_pkg::*;
	always_comb begin
		if (cfg.byte_count_select) begin
			cfg.transfer_count = {3'h0, cfg.count_upper_field, cfg.count_low};
			cfg.element_bits   = (cfg.width_field == 3'h0) ? TCW_FULL_ELEMENT
				: {1'b0, cfg.width_field};
		end else begin
			cfg.transfer_count = {cfg.count_upper_field, cfg.count_low, cfg.width_field};
			cfg.element_bits   = 4'h1;
		end
	end
endmodule : tcw_decode
`default_nettype wire

// ---- tcw_top.sv ----
// Register file and counter assembly for the serial transfer count configuration.
// Assumes an APB master and a shifting engine that reports busy.
// What this block does
// - In bit mode the upper field supplies counter bits 13-11.
// - In byte mode the upper field supplies counter bits 10-8.
// - In bit mode the width field supplies counter bits 2-0.
// - In byte mode width code 0 means 8 bits and codes 1-7 mean 1-7 bits.
// - Bits 31-3 of the upper and width registers read as zero.
`timescale 1ns/1ps
`default_nettype none
module tcw_top (
	input  wire logic              sys_clk_in,
	input  wire logic              arst_n_in,
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [7:0]        paddr_in,
	input  wire logic [31:0]       pwdata_in,
	input  wire logic              busy_in,
	output logic      [31:0]       prdata_out,
	output logic                   pready_out,
	output logic                   pslverr_out,
	output logic      [13:0]       transfer_count_out,
	output logic      [3:0]        element_bits_out,
	output logic                   byte_count_select_out
);
	import tcw_pkg::*;
	tcw_cfg_if cfg ();
	logic [2:0] count_upper_reg;
	logic [2:0] width_reg;
	logic [7:0] count_low_reg;
	logic       select_reg;
	logic       wr_en;
	logic       access;
	logic       mapped;
	logic [31:0] rd_next;

	// Unimplemented upper bits of a field register always read zero
	function automatic logic [31:0] pad_field(input logic [2:0] field);
		pad_field = {29'h0, field};
	endfunction : pad_field

	assign access = psel_in && penable_in;
	assign wr_en  = access && pwrite_in;
	assign mapped = (paddr_in == TCW_OFF_COUNT_LOW) || (paddr_in == TCW_OFF_COUNT_UPPER)
		|| (paddr_in == TCW_OFF_WIDTH) || (paddr_in == TCW_OFF_CONTROL)
		|| (paddr_in == TCW_OFF_STATUS);
	assign pready_out  = 1'b1;
	assign pslverr_out = access && !mapped;

	// Writes while busy are still taken; software keeps off them
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			count_upper_reg <= TCW_FIELD_RST;
		end else if (wr_en && paddr_in == TCW_OFF_COUNT_UPPER) begin
			count_upper_reg <= pwdata_in[2:0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			width_reg <= TCW_FIELD_RST;
		end else if (wr_en && paddr_in == TCW_OFF_WIDTH) begin
			width_reg <= pwdata_in[2:0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			count_low_reg <= TCW_LOW_RST;
		end else if (wr_en && paddr_in == TCW_OFF_COUNT_LOW) begin
			count_low_reg <= pwdata_in[7:0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			select_reg <= TCW_SELECT_RST;
		end else if (wr_en && paddr_in == TCW_OFF_CONTROL) begin
			select_reg <= pwdata_in[TCW_CTRL_SEL_BIT];
		end
	end

	always_comb begin
		rd_next = 32'h0000_0000;
		if (paddr_in == TCW_OFF_COUNT_LOW) begin
			rd_next = {24'h000000, count_low_reg};
		end else if (paddr_in == TCW_OFF_COUNT_UPPER) begin
			rd_next = pad_field(count_upper_reg);
		end else if (paddr_in == TCW_OFF_WIDTH) begin
			rd_next = pad_field(width_reg);
		end else if (paddr_in == TCW_OFF_CONTROL) begin
			rd_next = {31'h0, select_reg};
		end else if (paddr_in == TCW_OFF_STATUS) begin
			rd_next = {31'h0, busy_in};
		end
	end

	// Read data registered at setup so it is stable in the access phase
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			prdata_out <= rd_next;
		end
	end

	assign cfg.byte_count_select = select_reg;
	assign cfg.count_upper_field = count_upper_reg;
	assign cfg.count_low         = count_low_reg;
	assign cfg.width_field       = width_reg;

	tcw_decode u_decode (
		.cfg (cfg)
	);

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			transfer_count_out    <= 14'h0000;
			element_bits_out      <= TCW_FULL_ELEMENT;
			byte_count_select_out <= TCW_SELECT_RST;
		end else begin
			transfer_count_out    <= cfg.transfer_count;
			element_bits_out      <= cfg.element_bits;
			byte_count_select_out <= select_reg;
		end
	end

	// All checks run on the register clock and pause while reset is low
	default clocking cb_sys @(posedge sys_clk_in);
	endclocking
	default disable iff (!arst_n_in);

	sequence seq_upper_write;
		wr_en && paddr_in == TCW_OFF_COUNT_UPPER;
	endsequence

	sequence seq_width_write;
		wr_en && paddr_in == TCW_OFF_WIDTH;
	endsequence

	sequence seq_low_write;
		wr_en && paddr_in == TCW_OFF_COUNT_LOW;
	endsequence

	sequence seq_field_read;
		psel_in && !penable_in && !pwrite_in
			&& (paddr_in == TCW_OFF_COUNT_UPPER || paddr_in == TCW_OFF_WIDTH);
	endsequence

	sequence seq_unmapped_read;
		psel_in && !penable_in && !pwrite_in && !mapped;
	endsequence

	AST_BIT_UPPER: assert property (
		!select_reg |=> transfer_count_out[13:11] == $past(count_upper_reg))
		else $error("upper field not at bits 13-11");

	AST_BYTE_UPPER: assert property (
		select_reg |=> transfer_count_out[10:8] == $past(count_upper_reg)
			&& transfer_count_out[13:11] == 3'h0)
		else $error("upper field not at bits 10-8");

	AST_BIT_WIDTH: assert property (
		!select_reg |=> transfer_count_out[2:0] == $past(width_reg))
		else $error("width field not at bits 2-0");

	// Outputs take decoded values at the first edge after release
	AST_BIT_ELEM: assert property (
		arst_n_in && !select_reg |=> element_bits_out == 4'h1)
		else $error("element size not one in bit mode");

	AST_ELEM_SIZE: assert property (
		select_reg |=> element_bits_out == (($past(width_reg) == 3'h0) ? 4'h8
			: {1'b0, $past(width_reg)}))
		else $error("element size wrong");

	AST_READ_ZERO: assert property (
		seq_field_read |=> prdata_out[31:3] == 29'h0)
		else $error("unimplemented bits read nonzero");

	AST_FIELD_READ: assert property (
		seq_field_read |=> prdata_out[2:0]
			== $past((paddr_in == TCW_OFF_WIDTH) ? width_reg : count_upper_reg))
		else $error("field readback wrong");

	AST_UNMAPPED_READ: assert property (
		seq_unmapped_read |=> prdata_out == 32'h0000_0000)
		else $error("unmapped read nonzero");

	AST_LOW_MID: assert property (
		!select_reg |=> transfer_count_out[10:3] == $past(count_low_reg))
		else $error("low register not in middle bits");

	AST_BYTE_LOW: assert property (
		select_reg |=> transfer_count_out[7:0] == $past(count_low_reg))
		else $error("low register not at bits 7-0");

	AST_UPPER_WRITE: assert property (
		seq_upper_write |=> ##1
			(select_reg || transfer_count_out[13:11] == $past(pwdata_in[2:0], 2)))
		else $error("upper write not seen at counter");

	AST_BYTE_UPPER_WRITE: assert property (
		seq_upper_write |=> ##1
			(!select_reg || transfer_count_out[10:8] == $past(pwdata_in[2:0], 2)))
		else $error("upper write not seen in byte mode");

	AST_WIDTH_WRITE: assert property (
		seq_width_write |=> ##1
			(select_reg || transfer_count_out[2:0] == $past(pwdata_in[2:0], 2)))
		else $error("width write not seen at counter");

	AST_ELEM_WRITE: assert property (
		seq_width_write |=> ##1 (!select_reg || element_bits_out
			== (($past(pwdata_in[2:0], 2) == 3'h0) ? 4'h8 : {1'b0, $past(pwdata_in[2:0], 2)})))
		else $error("width write not seen as element size");

	AST_LOW_WRITE: assert property (
		seq_low_write |=> ##1 ((select_reg ? transfer_count_out[7:0]
			: transfer_count_out[10:3]) == $past(pwdata_in[7:0], 2)))
		else $error("low write not seen at counter");

	AST_SELECT_COPY: assert property (
		1'b1 |=> byte_count_select_out == $past(select_reg))
		else $error("select output does not follow control");
endmodule : tcw_top
`default_nettype wire

// ---- tcw_tb.sv ----
// Testbench for the transfer count and width configuration block.
// Assumes tcw_top answers APB with zero wait states and registered outputs.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb;
	import tcw_pkg::*;
	logic        clk    = 1'b0;
	logic        rst_n  = 1'b0;
	logic        psel   = 1'b0;
	logic        pen    = 1'b0;
	logic        pwr    = 1'b0;
	logic        busy   = 1'b0;
	logic [7:0]  paddr  = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic        sel;
	logic [13:0] cnt;
	logic [3:0]  elem;
	int          mismatches = 0;
	int          checks     = 0;
	tcw_top uut (.sys_clk_in(clk), .arst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .busy_in(busy),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.transfer_count_out(cnt), .element_bits_out(elem), .byte_count_select_out(sel));
	initial forever #4 clk = ~clk;
	task automatic close_out;
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : close_out
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n == 16) begin
			mismatches++;
			close_out();
		end
	endtask : apb
	// Outputs follow a register write one edge later
	task automatic settle;
		@(posedge clk);
		#1;
	endtask : settle
	task automatic t_reset;
		`CHK("count", 14'h0000, cnt)
		`CHK("elem", 4'h1, elem)
		apb(1'b0, TCW_OFF_COUNT_UPPER, 32'h0);
		`CHK("upper", 32'h0, rd)
		`CHK("slverr", 1'b0, err)
	endtask : t_reset
	task automatic t_bit;
		apb(1'b1, TCW_OFF_CONTROL, 32'h0);
		apb(1'b1, TCW_OFF_COUNT_UPPER, 32'hFFFF_FFFD);
		apb(1'b1, TCW_OFF_COUNT_LOW, 32'h0000_00A5);
		apb(1'b1, TCW_OFF_WIDTH, 32'hFFFF_FFFB);
		settle();
		`CHK("bit count", 14'h2D2B, cnt)
		apb(1'b0, TCW_OFF_COUNT_UPPER, 32'h0);
		`CHK("upper", 32'h5, rd)
		apb(1'b0, TCW_OFF_WIDTH, 32'h0);
		`CHK("width", 32'h3, rd)
	endtask : t_bit
	task automatic t_byte;
		logic [3:0] c;
		apb(1'b1, TCW_OFF_CONTROL, 32'h1);
		for (c = 4'h0; c < 4'h8; c++) begin
			apb(1'b1, TCW_OFF_WIDTH, {28'h0, c});
			settle();
			`CHK("elem", (c == 4'h0) ? 4'h8 : c, elem)
			`CHK("byte count", 14'h05A5, cnt)
		end
		`CHK("select", 1'b1, sel)
	endtask : t_byte
	// Mid-run reset: outputs take reset values, then bit mode resumes
	task automatic t_rearm;
		@(posedge clk);
		rst_n <= 1'b0;
		settle();
		`CHK("rst count", 14'h0000, cnt)
		`CHK("rst elem", 4'h8, elem)
		`CHK("rst select", 1'b0, sel)
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		`CHK("elem", 4'h1, elem)
		apb(1'b0, TCW_OFF_WIDTH, 32'h0);
		`CHK("width", 32'h0, rd)
	endtask : t_rearm
	task automatic t_bad;
		apb(1'b0, 8'h14, 32'h0);
		`CHK("slverr", 1'b1, err)
		`CHK("unmapped", 32'h0, rd)
		// Busy only raised while no config write is issued
		busy <= 1'b1;
		apb(1'b0, TCW_OFF_STATUS, 32'h0);
		`CHK("status", 32'h1, rd)
		busy <= 1'b0;
	endtask : t_bad
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		t_reset();
		t_bit();
		t_byte();
		t_rearm();
		t_bad();
		close_out();
	end
endmodule : tb
`default_nettype wire
